/* File: radio_cfg_pkg.sv */
/*
 Constants for the receive-chain and synthesizer configuration register bank.
 Assumes an 8-bit software register port addressed by full 16-bit offsets.
*/
package radio_cfg_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] LNA_BIAS_OFS = 16'hdf0d;
   localparam logic [15:0] RX_FILT_OFS = 16'hdf0e;
   localparam logic [15:0] MIX_BIAS_OFS = 16'hdf0f;
   localparam logic [15:0] SYN_HIGH_OFS = 16'hdf10;
   localparam logic [15:0] SYN_LOW_OFS = 16'hdf11;
   localparam logic [15:0] IRQ_STATUS_OFS = 16'hdf18;
   localparam logic [15:0] IRQ_MASK_OFS = 16'hdf19;
   localparam logic [7:0] LNA_BIAS_RST = 8'he5;
   localparam logic [5:0] RX_FILT_RST = 6'h2a;
   localparam logic [7:0] MIX_BIAS_RST = 8'h56;
   localparam logic [1:0] LOCK_SEL_RST = 2'h1;
   localparam logic LOCK_LEN_RST = 1'b0;
   localparam logic [1:0] CHAN_HIGH_RST = 2'h1;
   localparam logic [7:0] CHAN_LOW_RST = 8'h65;
   localparam int LNA_COMP_POS = 6;
   localparam int LNA_HIGH_POS = 4;
   localparam int LNA_MED_POS = 2;
   localparam int LNA_LOW_POS = 0;
   localparam int FILT_LOW_BIAS_POS = 5;
   localparam int FILT_MID_BIAS_POS = 4;
   localparam int LOW_REDUCED_POS = 3;
   localparam int MED_REDUCED_POS = 2;
   localparam int HIGH_BOOST_POS = 1;
   localparam int MED_BOOST_POS = 0;
   localparam int MIX_VAR_POS = 6;
   localparam int MIX_TAIL_POS = 4;
   localparam int MIX_CM_POS = 2;
   localparam int MIX_CUR_POS = 0;
   localparam int CHAN_HIGH_POS = 0;
   localparam int LOCK_SEL_POS = 6;
   localparam int CAL_DONE_POS = 5;
   localparam int CAL_RUN_POS = 4;
   localparam int LOCK_LEN_POS = 3;
   localparam int LOCK_STAT_POS = 2;
   localparam logic [11:0] RF_BASE_MHZ = 12'h800;
   localparam logic [11:0] RX_LO_OFFSET_MHZ = 12'h002;
   localparam logic [9:0] LOCK_COUNT_BASE = 10'h040;
   localparam logic [2:0] LOCK_WIN_SHORT = 3'h2;
   localparam logic [2:0] LOCK_WIN_LONG = 3'h4;
   localparam int IRQ_W = 4;
   localparam int IRQ_CAL_DONE = 0;
   localparam int IRQ_LOCK_GAIN = 1;
   localparam int IRQ_LOCK_LOSS = 2;
   localparam int IRQ_CAL_START = 3;
endpackage

/* File: radio_cfg_sva.sv */
/*
 Port checker for the radio configuration bank.
 Assumes it is bound to radio_rx_synth_config_regs.
*/
`timescale 1ns/1ns
`default_nettype none
module radio_cfg_sva import radio_cfg_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic receive_active,
   input wire logic [1:0] amp_varactor_select,
   input wire logic [1:0] mixer_tail_current,
   input wire logic [1:0] mixer_common_mode_level,
   input wire logic [1:0] mixer_bias_current,
   input wire logic [9:0] lock_count_threshold,
   input wire logic [2:0] lock_window_periods,
   input wire logic [9:0] channel_word,
   input wire logic [11:0] rf_channel_word_mhz,
   input wire logic [11:0] lo_channel_word_mhz
);
   logic [7:0] wd_q;
   always_ff @(posedge clk) begin
      wd_q <= wdata;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr(logic [15:0] a);
      wr_stb && addr == a;
   endsequence
   property p_rsv;
      rd_stb && addr == RX_FILT_OFS |=> rdata[7:6] == 2'b00;
   endproperty
   property p_thr;
      s_wr(SYN_HIGH_OFS) |=> lock_count_threshold == (LOCK_COUNT_BASE << wd_q[7:6]);
   endproperty
   property p_win;
      s_wr(SYN_HIGH_OFS) |=> lock_window_periods == (wd_q[3] ? 3'h4 : 3'h2);
   endproperty
   property p_chan_hi;
      s_wr(SYN_HIGH_OFS) |=> channel_word[9:8] == wd_q[1:0];
   endproperty
   property p_chan_lo;
      s_wr(SYN_LOW_OFS) |=> channel_word[7:0] == wd_q ##1 $stable(channel_word);
   endproperty
   property p_mix;
      s_wr(MIX_BIAS_OFS) |=> {amp_varactor_select, mixer_tail_current,
         mixer_common_mode_level, mixer_bias_current} == wd_q;
   endproperty
   property p_rf;
      rf_channel_word_mhz == RF_BASE_MHZ + {2'b00, channel_word};
   endproperty
   property p_lo;
      lo_channel_word_mhz == rf_channel_word_mhz - (receive_active ? RX_LO_OFFSET_MHZ : 12'h000);
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   a_thr: assert property (p_thr) else $error("lock threshold wrong");
   a_win: assert property (p_win) else $error("lock window wrong");
   a_chan_hi: assert property (p_chan_hi) else $error("channel high wrong");
   a_chan_lo: assert property (p_chan_lo) else $error("channel low wrong");
   a_mix: assert property (p_mix) else $error("mixer fields wrong");
   a_rf: assert property (p_rf) else $error("rf frequency wrong");
   a_lo: assert property (p_lo) else $error("lo frequency wrong");
endmodule
`default_nettype wire

/* File: radio_rx_synth_config_regs.sv */
/*
 Register bank holding receive-chain bias and gain-mode settings and the
 synthesizer controls, with live calibration and lock status and an interrupt.
 Assumes synthesizer status inputs come from another clock domain and are
 synchronised here; software uses a plain strobe port with read data a cycle later.
*/
`timescale 1ns/1ns
`default_nettype none
module radio_rx_synth_config_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic [radio_cfg_pkg::ADDR_W-1:0] addr,
   input wire logic [radio_cfg_pkg::DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [radio_cfg_pkg::DATA_W-1:0] rdata,
   input wire logic synth_on,
   input wire logic cal_running_in,
   input wire logic pll_locked_in,
   input wire logic receive_active,
   output logic [1:0] low_step_compensation_current,
   output logic [1:0] high_step_amp_current,
   output logic [1:0] medium_step_amp_current,
   output logic [1:0] low_step_amp_current,
   output logic filter_low_bias_select,
   output logic filter_mid_bias_select,
   output logic low_step_amp_reduced_gain,
   output logic medium_step_amp_reduced_gain,
   output logic high_step_mixer_boost,
   output logic medium_step_mixer_boost,
   output logic [1:0] amp_varactor_select,
   output logic [1:0] mixer_tail_current,
   output logic [1:0] mixer_common_mode_level,
   output logic [1:0] mixer_bias_current,
   output logic [9:0] lock_count_threshold,
   output logic [2:0] lock_window_periods,
   output logic [9:0] channel_word,
   output logic [11:0] rf_channel_word_mhz,
   output logic [11:0] lo_channel_word_mhz,
   output logic [11:0] synth_divider_x4,
   output logic irq
);
   import radio_cfg_pkg::*;

   // Writable fields, one register per field except rx_filt_ff, which holds all six filter bits
   logic [1:0] comp_cur_ff;
   logic [1:0] high_cur_ff;
   logic [1:0] med_cur_ff;
   logic [1:0] low_cur_ff;
   logic [5:0] rx_filt_ff;
   logic [1:0] varactor_ff;
   logic [1:0] tail_cur_ff;
   logic [1:0] cm_level_ff;
   logic [1:0] mix_cur_ff;
   logic [1:0] lock_sel_ff;
   logic lock_len_ff;
   logic [1:0] chan_high_ff;
   logic [7:0] chan_low_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   // Synchroniser stages, edge history and status
   logic [2:0] sync1_ff;
   logic [2:0] sync2_ff;
   logic on_prev_ff;
   logic cal_prev_ff;
   logic lock_prev_ff;
   logic cal_done_ff;
   logic [IRQ_W-1:0] irq_status_ff;
   // Decodes, edges and read paths
   logic wr_lna;
   logic wr_filt;
   logic wr_mix;
   logic wr_syn_high;
   logic wr_syn_low;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic on_s;
   logic cal_run_s;
   logic lock_s;
   logic on_rise;
   logic cal_rise;
   logic cal_fall;
   logic lock_rise;
   logic lock_fall;
   logic [IRQ_W-1:0] irq_event;
   logic [IRQ_W-1:0] irq_clear;
   logic [7:0] lna_bias_rd;
   logic [7:0] mix_bias_rd;
   logic [7:0] syn_high_rd;
   logic [7:0] irq_status_rd;
   logic [7:0] irq_mask_rd;
   logic [7:0] nxt_rdata;
   logic [9:0] chan_word;
   logic [11:0] rf_sum;

   // Status lines cross from the synthesizer domain; only stage two is read
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 3'h0;
      end else begin
         sync1_ff <= {synth_on, cal_running_in, pll_locked_in};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync2_ff <= 3'h0;
      end else begin
         sync2_ff <= sync1_ff;
      end
   end

   assign on_s = sync2_ff[2];
   assign cal_run_s = sync2_ff[1];
   assign lock_s = sync2_ff[0];

   // Full 16-bit compare, so no alias of the bank ever decodes
   assign wr_lna = wr_stb && (addr == LNA_BIAS_OFS);
   assign wr_filt = wr_stb && (addr == RX_FILT_OFS);
   assign wr_mix = wr_stb && (addr == MIX_BIAS_OFS);
   assign wr_syn_high = wr_stb && (addr == SYN_HIGH_OFS);
   assign wr_syn_low = wr_stb && (addr == SYN_LOW_OFS);
   assign wr_irq_status = wr_stb && (addr == IRQ_STATUS_OFS);
   assign wr_irq_mask = wr_stb && (addr == IRQ_MASK_OFS);

   always_ff @(posedge clk) begin
      if (rst) begin
         comp_cur_ff <= LNA_BIAS_RST[LNA_COMP_POS +: 2];
      end else if (wr_lna) begin
         comp_cur_ff <= wdata[LNA_COMP_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         high_cur_ff <= LNA_BIAS_RST[LNA_HIGH_POS +: 2];
      end else if (wr_lna) begin
         high_cur_ff <= wdata[LNA_HIGH_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         med_cur_ff <= LNA_BIAS_RST[LNA_MED_POS +: 2];
      end else if (wr_lna) begin
         med_cur_ff <= wdata[LNA_MED_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         low_cur_ff <= LNA_BIAS_RST[LNA_LOW_POS +: 2];
      end else if (wr_lna) begin
         low_cur_ff <= wdata[LNA_LOW_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_filt_ff <= RX_FILT_RST;
      end else if (wr_filt) begin
         rx_filt_ff <= wdata[5:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         varactor_ff <= MIX_BIAS_RST[MIX_VAR_POS +: 2];
      end else if (wr_mix) begin
         varactor_ff <= wdata[MIX_VAR_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tail_cur_ff <= MIX_BIAS_RST[MIX_TAIL_POS +: 2];
      end else if (wr_mix) begin
         tail_cur_ff <= wdata[MIX_TAIL_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cm_level_ff <= MIX_BIAS_RST[MIX_CM_POS +: 2];
      end else if (wr_mix) begin
         cm_level_ff <= wdata[MIX_CM_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mix_cur_ff <= MIX_BIAS_RST[MIX_CUR_POS +: 2];
      end else if (wr_mix) begin
         mix_cur_ff <= wdata[MIX_CUR_POS +: 2];
      end
   end

   // Only the writable fields take the write; status bits stay live
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_sel_ff <= LOCK_SEL_RST;
      end else if (wr_syn_high) begin
         lock_sel_ff <= wdata[LOCK_SEL_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_len_ff <= LOCK_LEN_RST;
      end else if (wr_syn_high) begin
         lock_len_ff <= wdata[LOCK_LEN_POS];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chan_high_ff <= CHAN_HIGH_RST;
      end else if (wr_syn_high) begin
         chan_high_ff <= wdata[CHAN_HIGH_POS +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         chan_low_ff <= CHAN_LOW_RST;
      end else if (wr_syn_low) begin
         chan_low_ff <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_ff <= {IRQ_W{1'b0}};
      end else if (wr_irq_mask) begin
         irq_mask_ff <= wdata[IRQ_W-1:0];
      end
   end

   // Histories reset to the idle level of each line, so no false edge follows reset
   always_ff @(posedge clk) begin
      if (rst) begin
         on_prev_ff <= 1'b0;
      end else begin
         on_prev_ff <= on_s;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cal_prev_ff <= 1'b0;
      end else begin
         cal_prev_ff <= cal_run_s;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_prev_ff <= 1'b0;
      end else begin
         lock_prev_ff <= lock_s;
      end
   end

   assign on_rise = on_s && !on_prev_ff;
   assign cal_rise = cal_run_s && !cal_prev_ff;
   assign cal_fall = !cal_run_s && cal_prev_ff;
   assign lock_rise = lock_s && !lock_prev_ff;
   assign lock_fall = !lock_s && lock_prev_ff;

   // Turn-on wins over a finish in the same cycle: that finish is of the old session
   always_ff @(posedge clk) begin
      if (rst) begin
         cal_done_ff <= 1'b0;
      end else if (on_rise) begin
         cal_done_ff <= 1'b0;
      end else if (on_s && cal_fall) begin
         cal_done_ff <= 1'b1;
      end
   end

   assign irq_event[IRQ_CAL_DONE] = on_s && cal_fall;
   assign irq_event[IRQ_LOCK_GAIN] = lock_rise;
   assign irq_event[IRQ_LOCK_LOSS] = lock_fall;
   assign irq_event[IRQ_CAL_START] = cal_rise;
   assign irq_clear = wr_irq_status ? wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

   // Set wins over a clear in the same cycle, so no event is lost to a late clear
   for (genvar i = 0; i < IRQ_W; i++) begin : g_status
      always_ff @(posedge clk) begin
         if (rst) begin
            irq_status_ff[i] <= 1'b0;
         end else if (irq_event[i]) begin
            irq_status_ff[i] <= 1'b1;
         end else if (irq_clear[i]) begin
            irq_status_ff[i] <= 1'b0;
         end
      end
   end

   assign irq = |(irq_status_ff & irq_mask_ff);

   assign lna_bias_rd = {comp_cur_ff, high_cur_ff, med_cur_ff, low_cur_ff};
   assign mix_bias_rd = {varactor_ff, tail_cur_ff, cm_level_ff, mix_cur_ff};

   always_comb begin
      syn_high_rd = 8'h00;
      syn_high_rd[LOCK_SEL_POS +: 2] = lock_sel_ff;
      syn_high_rd[CAL_DONE_POS] = cal_done_ff;
      syn_high_rd[CAL_RUN_POS] = cal_run_s;
      syn_high_rd[LOCK_LEN_POS] = lock_len_ff;
      syn_high_rd[LOCK_STAT_POS] = lock_s;
      syn_high_rd[CHAN_HIGH_POS +: 2] = chan_high_ff;
   end

   assign irq_status_rd = {{(8 - IRQ_W){1'b0}}, irq_status_ff};
   assign irq_mask_rd = {{(8 - IRQ_W){1'b0}}, irq_mask_ff};

   always_comb begin
      case (addr)
         LNA_BIAS_OFS: nxt_rdata = lna_bias_rd;
         RX_FILT_OFS: nxt_rdata = {2'b00, rx_filt_ff};
         MIX_BIAS_OFS: nxt_rdata = mix_bias_rd;
         SYN_HIGH_OFS: nxt_rdata = syn_high_rd;
         SYN_LOW_OFS: nxt_rdata = chan_low_ff;
         IRQ_STATUS_OFS: nxt_rdata = irq_status_rd;
         IRQ_MASK_OFS: nxt_rdata = irq_mask_rd;
         default: nxt_rdata = 8'h00;
      endcase
   end

   // Read data stands for one cycle only, zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         rdata <= nxt_rdata;
      end else begin
         rdata <= 8'h00;
      end
   end

   assign low_step_compensation_current = comp_cur_ff;
   assign high_step_amp_current = high_cur_ff;
   assign medium_step_amp_current = med_cur_ff;
   assign low_step_amp_current = low_cur_ff;
   assign filter_low_bias_select = rx_filt_ff[FILT_LOW_BIAS_POS];
   assign filter_mid_bias_select = rx_filt_ff[FILT_MID_BIAS_POS];
   assign low_step_amp_reduced_gain = rx_filt_ff[LOW_REDUCED_POS];
   assign medium_step_amp_reduced_gain = rx_filt_ff[MED_REDUCED_POS];
   assign high_step_mixer_boost = rx_filt_ff[HIGH_BOOST_POS];
   assign medium_step_mixer_boost = rx_filt_ff[MED_BOOST_POS];
   assign amp_varactor_select = varactor_ff;
   assign mixer_tail_current = tail_cur_ff;
   assign mixer_common_mode_level = cm_level_ff;
   assign mixer_bias_current = mix_cur_ff;
   assign lock_count_threshold = LOCK_COUNT_BASE << lock_sel_ff;
   assign lock_window_periods = lock_len_ff ? LOCK_WIN_LONG : LOCK_WIN_SHORT;
   assign chan_word = {chan_high_ff, chan_low_ff};
   assign channel_word = chan_word;
   assign rf_sum = RF_BASE_MHZ + {2'b00, chan_word};
   assign rf_channel_word_mhz = rf_sum;
   // Divider output carries the integer sum rf_sum unscaled, with no fraction bits
   assign synth_divider_x4 = rf_sum;
   assign lo_channel_word_mhz = receive_active ? rf_sum - RX_LO_OFFSET_MHZ : rf_sum;
endmodule
`default_nettype wire

/* File: radio_synth_model.sv */
/*
 Behavioural analog synthesizer: power, calibration and lock levels.
 Assumes the bench calls its tasks from the clk domain.
*/
`timescale 1ns/1ns
`default_nettype none
module radio_synth_model #(parameter int LOCK_DELAY = 5) (
   input wire logic clk,
   output logic synth_on,
   output logic cal_running_in,
   output logic pll_locked_in
);
   initial begin
      synth_on = 1'b0;
      cal_running_in = 1'b0;
      pll_locked_in = 1'b0;
   end
   task power(input logic on);
      @(posedge clk);
      synth_on <= on;
      // Lock is lost whenever the loop is switched
      pll_locked_in <= 1'b0;
   endtask
   task calibrate(input int n);
      @(posedge clk);
      cal_running_in <= 1'b1;
      repeat (n) @(posedge clk);
      cal_running_in <= 1'b0;
      repeat (LOCK_DELAY) @(posedge clk);
      pll_locked_in <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: tb_radio_rx_synth_config_regs.sv */
/*
 Self-checking bench for the radio configuration bank.
 Assumes the synthesizer model and the bound checker beside it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_radio_rx_synth_config_regs;
   import radio_cfg_pkg::*;
   logic clk, rst, wr_stb, rd_stb, receive_active, irq;
   logic [15:0] addr;
   logic [7:0] wdata, rdata;
   logic [9:0] lock_count_threshold;
   logic [2:0] lock_window_periods;
   logic [11:0] rf_channel_word_mhz, lo_channel_word_mhz, synth_divider_x4;
   logic [7:0] lna_f;
   logic [5:0] filt_f;
   wire logic synth_on, cal_running_in, pll_locked_in;
   int mismatches = 0;
   int check_count = 0;
   radio_synth_model m (.clk(clk), .synth_on(synth_on), .cal_running_in(cal_running_in),
      .pll_locked_in(pll_locked_in));
   radio_rx_synth_config_regs dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .synth_on(synth_on),
      .cal_running_in(cal_running_in), .pll_locked_in(pll_locked_in),
      .receive_active(receive_active), .low_step_compensation_current(lna_f[7:6]),
      .high_step_amp_current(lna_f[5:4]), .medium_step_amp_current(lna_f[3:2]),
      .low_step_amp_current(lna_f[1:0]), .filter_low_bias_select(filt_f[5]),
      .filter_mid_bias_select(filt_f[4]), .low_step_amp_reduced_gain(filt_f[3]),
      .medium_step_amp_reduced_gain(filt_f[2]), .high_step_mixer_boost(filt_f[1]),
      .medium_step_mixer_boost(filt_f[0]),
      .amp_varactor_select(), .mixer_tail_current(), .mixer_common_mode_level(),
      .mixer_bias_current(), .lock_count_threshold(lock_count_threshold),
      .lock_window_periods(lock_window_periods), .channel_word(), .rf_channel_word_mhz(rf_channel_word_mhz),
      .lo_channel_word_mhz(lo_channel_word_mhz), .synth_divider_x4(synth_divider_x4), .irq(irq));
   task close_out;
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 chk({4'h0, rdata}, {4'h0, e});
   endtask
   task t_reset;
      rd(LNA_BIAS_OFS, 8'he5);
      rd(RX_FILT_OFS, 8'h2a);
      rd(MIX_BIAS_OFS, 8'h56);
      rd(SYN_HIGH_OFS, 8'h41);
      rd(SYN_LOW_OFS, 8'h65);
      rd(16'hdf12, 8'h00);
      chk(rf_channel_word_mhz, 12'h965);
      chk({4'h0, lna_f}, 12'h0e5);
      chk({6'h00, filt_f}, 12'h02a);
   endtask
   task t_write_all(input logic [7:0] d);
      wr(LNA_BIAS_OFS, d);
      wr(RX_FILT_OFS, d);
      wr(MIX_BIAS_OFS, d);
      wr(SYN_HIGH_OFS, d);
      wr(SYN_LOW_OFS, d);
      rd(LNA_BIAS_OFS, d);
      rd(RX_FILT_OFS, d & 8'h3f);
      rd(MIX_BIAS_OFS, d);
      rd(SYN_HIGH_OFS, d & 8'hcb);
      rd(SYN_LOW_OFS, d);
      chk({2'b00, lock_count_threshold}, 12'h040 << d[7:6]);
      chk({9'h0, lock_window_periods}, d[3] ? 12'h4 : 12'h2);
      chk(synth_divider_x4, 12'h800 + {2'b00, d[1:0], d});
      chk({4'h0, lna_f}, {4'h0, d});
      chk({6'h00, filt_f}, {6'h00, d[5:0]});
      @(posedge clk);
      receive_active <= 1'b1;
      #1 chk(lo_channel_word_mhz, 12'h7fe + {2'b00, d[1:0], d});
      @(posedge clk);
      receive_active <= 1'b0;
   endtask
   task t_cal;
      m.power(1'b1);
      fork
         m.calibrate(10);
         begin
            repeat (6) @(posedge clk);
            rd(SYN_HIGH_OFS, 8'h10);
         end
      join
      repeat (4) @(posedge clk);
      rd(SYN_HIGH_OFS, 8'h24);
      rd(IRQ_STATUS_OFS, 8'h0b);
      chk({11'h0, irq}, 12'h0);
      wr(IRQ_MASK_OFS, 8'h01);
      #1 chk({11'h0, irq}, 12'h1);
      wr(IRQ_STATUS_OFS, 8'h01);
      #1 chk({11'h0, irq}, 12'h0);
      m.power(1'b0);
      m.power(1'b1);
      repeat (4) @(posedge clk);
      rd(SYN_HIGH_OFS, 8'h00);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 16'h0000;
      wdata = 8'h00;
      receive_active = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_write_all(8'hff);
      t_write_all(8'h96);
      t_write_all(8'h00);
      t_cal;
      close_out;
   end
   // Whole run is about 130 cycles, so this margin only trips on a hang
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
endmodule
bind radio_rx_synth_config_regs radio_cfg_sva chk_i (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
   .receive_active(receive_active), .amp_varactor_select(amp_varactor_select),
   .mixer_tail_current(mixer_tail_current), .mixer_common_mode_level(mixer_common_mode_level),
   .mixer_bias_current(mixer_bias_current), .lock_count_threshold(lock_count_threshold),
   .lock_window_periods(lock_window_periods), .channel_word(channel_word),
   .rf_channel_word_mhz(rf_channel_word_mhz), .lo_channel_word_mhz(lo_channel_word_mhz));
`default_nettype wire
